//--- hw/plsc_codec.sv
// Serial link codec: host word latch, buffer, block encoder, NRZI serialiser,
// and the receiving deframer, decoder and cascade claim logic.
// Assumes a host on a four-phase strobe/acknowledge handshake and a peer
// sending one code bit per clk on serial_line_in; all pins but ce asynchronous.
`timescale 1ns/1ps
`include "plsc_regs.svh"
module plsc_codec #(
    parameter int DATA_W = `PLSC_DATA_W
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    input  wire logic                          input_strobe,
    input  wire logic [DATA_W-1:0]             data_in,
    input  wire logic [`PLSC_WORD_W-DATA_W-1:0] command_in,
    output logic                               input_ack_out,
    output logic                               serial_line_out,
    input  wire logic                          serial_line_in,
    input  wire logic                          capture_next_byte_in,
    input  wire logic                          cascade_en,
    output logic [DATA_W-1:0]                  data_out,
    output logic [`PLSC_WORD_W-DATA_W-1:0]      command_out,
    output logic                               data_strobe_out,
    output logic                               command_strobe_out,
    output logic                               byte_claimed_out,
    output logic                               link_framed_out
);
    // ****************************************
    // Widths of the code group
    // ****************************************
    // width split
    localparam int CMD_W = `PLSC_WORD_W - DATA_W;
    localparam int HW    = (DATA_W >= 9) ? 6 : 5;
    localparam int LW    = (DATA_W == 10) ? 6 : 5;
    localparam int W     = HW + LW;
    localparam int LDW   = LW - 1;
    localparam int HDW   = DATA_W - LDW;
    localparam int SW    = 4 + `PLSC_WORD_W;

    localparam logic [5:0] SYNC_HI = (HW == 6) ? `PLSC_SYNC6_HI : {1'h0, `PLSC_SYNC5_HI};
    localparam logic [5:0] SYNC_LO = (LW == 6) ? `PLSC_SYNC6_LO : {1'h0, `PLSC_SYNC5_LO};
    localparam logic [5:0] CMD_MK  = (HW == 6) ? `PLSC_CMD6 : {1'h0, `PLSC_CMD5};
    localparam logic       HI6     = (HW == 6);
    localparam logic       LO6     = (LW == 6);

    function automatic logic [11:0] pack(input logic [5:0] hi, input logic [5:0] lo);
        return ({6'h00, hi} << LW) | {6'h00, lo};
    endfunction

    // sync halves lie outside the data and command tables
    localparam logic [11:0] SYNC_GRP = pack(SYNC_HI, SYNC_LO);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [SW-1:0]            s_q;
    logic                     s_input_strobe, s_cnb, s_line, s_casc;
    logic [`PLSC_WORD_W-1:0]  s_word;

    plsc_sync2 #(.WIDTH(SW)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     ({command_in, data_in, cascade_en, serial_line_in, capture_next_byte_in, input_strobe}),
        .q     (s_q)
    );

    assign s_input_strobe = s_q[0];
    assign s_cnb  = s_q[1];
    assign s_line = s_q[2];
    assign s_casc = s_q[3];
    assign s_word = s_q[SW-1:4];

    // ****************************************
    // Host latch and handshake
    // ****************************************
    plsc_strm_if #(.WIDTH(`PLSC_WORD_W)) fi ();
    plsc_strm_if #(.WIDTH(`PLSC_WORD_W)) fo ();

    logic                    lat_full_r, lat_full_nxt;
    logic [`PLSC_WORD_W-1:0] lat_word_r, lat_word_nxt;
    logic                    ack_r, ack_nxt;
    logic                    defer_r, defer_nxt;
    logic                    accept, win;

    assign fi.valid = lat_full_r;
    assign fi.data  = lat_word_r;

    always_comb begin
        // busy strobe waits for the byte window
        accept       = s_input_strobe & ~ack_r & ~lat_full_r & (~defer_r | win);
        lat_full_nxt = lat_full_r;
        lat_word_nxt = lat_word_r;
        ack_nxt      = ack_r;
        defer_nxt    = defer_r;
        if (ce) begin
            if (s_input_strobe && !ack_r && lat_full_r) begin
                defer_nxt = 1'h1;
            end
            if (accept) begin
                lat_full_nxt = 1'h1;
                lat_word_nxt = s_word;
                defer_nxt    = 1'h0;
            end else if (fi.ready) begin
                lat_full_nxt = 1'h0;
            end
            if (accept) begin
                ack_nxt = 1'h1;
            end else if (!s_input_strobe) begin
                ack_nxt = 1'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_full_r <= 1'h0;
            lat_word_r <= '0;
            ack_r      <= 1'h0;
            defer_r    <= 1'h0;
        end else begin
            lat_full_r <= lat_full_nxt;
            lat_word_r <= lat_word_nxt;
            ack_r      <= ack_nxt;
            defer_r    <= defer_nxt;
        end
    end

    assign input_ack_out = ack_r;

    plsc_fifo #(
        .WIDTH (`PLSC_WORD_W),
        .DEPTH (`PLSC_FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .wr    (fi),
        .rd    (fo)
    );

    // ****************************************
    // Encoder, shifter and line driver
    // ****************************************
    logic [3:0]  tx_cnt_r, tx_cnt_nxt;
    logic [11:0] sh_r, sh_nxt, grp;
    logic        line_r, line_nxt;

    assign win      = (tx_cnt_r == 4'(W - 1));
    assign fo.ready = win;

    always_comb begin
        if (!fo.valid) begin
            grp = SYNC_GRP;
        end else if (fo.data[`PLSC_WORD_W-1:DATA_W] != '0) begin
            grp = pack(CMD_MK, plsc_pkg::plsc_enc(5'(fo.data[`PLSC_WORD_W-1:DATA_W]), LO6));
        end else begin
            grp = pack(plsc_pkg::plsc_enc(5'(fo.data[DATA_W-1:LDW]), HI6),
                       plsc_pkg::plsc_enc(5'(fo.data[LDW-1:0]), LO6));
        end
        tx_cnt_nxt = tx_cnt_r;
        sh_nxt     = sh_r;
        line_nxt   = line_r;
        if (ce) begin
            tx_cnt_nxt = win ? 4'h0 : tx_cnt_r + 4'h1;
            // one code bit per clock, group loaded each byte window
            sh_nxt     = win ? grp : {sh_r[10:0], 1'h0};
            line_nxt   = line_r ^ sh_r[W-1];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_r <= 4'h0;
            sh_r     <= SYNC_GRP;
            line_r   <= `PLSC_LINE_RST;
        end else begin
            tx_cnt_r <= tx_cnt_nxt;
            sh_r     <= sh_nxt;
            line_r   <= line_nxt;
        end
    end

    assign serial_line_out = line_r;

    // ****************************************
    // Receiver: NRZI decode, framing, symbol decode
    // ****************************************
    plsc_pkg::plsc_rx_st_t  rx_st_r, rx_st_nxt;
    logic                   prev_r, prev_nxt;
    logic [11:0]            rx_sh_r, rx_sh_nxt, rx_grp;
    logic [3:0]             rx_cnt_r, rx_cnt_nxt, cnt_inc;
    logic [DATA_W-1:0]      data_r, data_nxt;
    logic [CMD_W-1:0]       cmd_r, cmd_nxt;
    logic                   dstb_r, dstb_nxt, cstb_r, cstb_nxt;
    logic                   claim_r, claim_nxt;
    logic                   framed, rx_bit;
    logic [5:0]             hi, lo, first, dh, dl;

    always_comb begin
        framed    = (rx_st_r == plsc_pkg::PLSC_RX_FRAMED);
        rx_bit    = s_line ^ prev_r;
        rx_sh_nxt = {rx_sh_r[10:0], rx_bit};
        rx_grp    = rx_sh_nxt & 12'((13'h1 << W) - 13'h1);
        cnt_inc   = rx_cnt_r + 4'h1;
        hi        = 6'(rx_grp >> LW);
        lo        = LO6 ? rx_grp[5:0] : {1'h0, rx_grp[4:0]};
        first     = HI6 ? rx_sh_nxt[5:0] : {1'h0, rx_sh_nxt[4:0]};
        dh        = plsc_pkg::plsc_dec(hi, HI6);
        dl        = plsc_pkg::plsc_dec(lo, LO6);
        prev_nxt  = s_line;
        rx_st_nxt = rx_st_r;
        rx_cnt_nxt = framed ? ((cnt_inc == 4'(W)) ? 4'h0 : cnt_inc) : rx_cnt_r;
        data_nxt  = data_r;
        cmd_nxt   = cmd_r;
        dstb_nxt  = 1'h0;
        cstb_nxt  = 1'h0;
        claim_nxt = claim_r;
        if (framed && cnt_inc == 4'(HW)) begin
            // sync first half drops the claim
            if (first == SYNC_HI) begin
                claim_nxt = 1'h0;
            // claim on a non-sync first half
            end else if (s_cnb) begin
                claim_nxt = 1'h1;
            end
        end
        // capture input low drops the claim
        if (!s_cnb) begin
            claim_nxt = 1'h0;
        end
        if (rx_grp == SYNC_GRP) begin
            rx_st_nxt  = plsc_pkg::PLSC_RX_FRAMED;
            rx_cnt_nxt = 4'h0;
        // sync never reaches this branch, so outputs hold
        end else if (framed && cnt_inc == 4'(W) && (!s_casc || claim_r)) begin
            if (hi == CMD_MK) begin
                if (dl[5]) begin
                    cmd_nxt  = CMD_W'(dl[4:0]);
                    cstb_nxt = 1'h1;
                end
            // strobe only with a fully valid word
            end else if (dh[5] && dl[5]) begin
                data_nxt = {dh[HDW-1:0], dl[LDW-1:0]};
                dstb_nxt = 1'h1;
            end
        end
        if (!ce) begin
            prev_nxt   = prev_r;
            rx_sh_nxt  = rx_sh_r;
            rx_st_nxt  = rx_st_r;
            rx_cnt_nxt = rx_cnt_r;
            data_nxt   = data_r;
            cmd_nxt    = cmd_r;
            dstb_nxt   = dstb_r;
            cstb_nxt   = cstb_r;
            claim_nxt  = claim_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r  <= plsc_pkg::PLSC_RX_HUNT;
            prev_r   <= 1'h0;
            rx_sh_r  <= 12'h000;
            rx_cnt_r <= 4'h0;
            data_r   <= '0;
            cmd_r    <= '0;
            dstb_r   <= 1'h0;
            cstb_r   <= 1'h0;
            claim_r  <= 1'h0;
        end else begin
            rx_st_r  <= rx_st_nxt;
            prev_r   <= prev_nxt;
            rx_sh_r  <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            data_r   <= data_nxt;
            cmd_r    <= cmd_nxt;
            dstb_r   <= dstb_nxt;
            cstb_r   <= cstb_nxt;
            claim_r  <= claim_nxt;
        end
    end

    assign data_out           = data_r;
    assign command_out        = cmd_r;
    assign data_strobe_out    = dstb_r;
    assign command_strobe_out = cstb_r;
    assign byte_claimed_out   = claim_r;
    assign link_framed_out    = rx_st_r;
endmodule // plsc_codec

//--- hw/plsc_fifo.sv
// Word FIFO with registered head; valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
`include "plsc_regs.svh"
module plsc_fifo #(
    parameter int WIDTH = `PLSC_WORD_W,
    parameter int DEPTH = `PLSC_FIFO_DEPTH
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  ce,
    plsc_strm_if.snk   wr,
    plsc_strm_if.src   rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic [WIDTH-1:0] q_r, q_nxt;
    logic             vld_r, vld_nxt, push, pop;

    assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd.valid = vld_r;
    assign rd.data  = q_r;

    // ****************************************
    // Pointers and head register
    // ****************************************
    always_comb begin
        push    = ce & wr.valid & wr.ready;
        pop     = ce & vld_r & rd.ready;
        wp_nxt  = push ? wp_r + 1'h1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'h1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        vld_nxt = (cnt_nxt != '0);
        // Bypass a word written into the slot that becomes the head
        q_nxt   = (push && wp_r == rp_nxt) ? wr.data : mem[rp_nxt];
        if (!ce) begin
            q_nxt = q_r;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            q_r   <= '0;
            vld_r <= 1'h0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            q_r   <= q_nxt;
            vld_r <= vld_nxt;
        end
    end
endmodule // plsc_fifo

//--- hw/plsc_sync2.sv
// Two-stage synchroniser, one chain per bit.
// Assumes inputs asynchronous to clk.
`timescale 1ns/1ps
module plsc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    // ****************************************
    // Per-bit chains
    // ****************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_r;
        logic meta_nxt;
        logic q_nxt;
        always_comb begin
            meta_nxt = ce ? d[i] : meta_r;
            q_nxt    = ce ? meta_r : q[i];
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_r <= 1'h0;
                q[i]   <= 1'h0;
            end else begin
                meta_r <= meta_nxt;
                q[i]   <= q_nxt;
            end
        end
    end
endmodule // plsc_sync2

//--- shared/plsc_pkg.sv
// Types and symbol tables of the serial link codec.
// Assumes plsc_regs.svh on the include path.
`include "plsc_regs.svh"
package plsc_pkg;
    typedef enum logic [0:0] {
        PLSC_RX_HUNT   = 1'h0,
        PLSC_RX_FRAMED = 1'h1
    } plsc_rx_st_t;

    typedef logic [`PLSC_WORD_W-1:0] plsc_word_t;

    // ****************************************
    // Four-bit and five-bit value code tables
    // ****************************************
    parameter logic [4:0] PLSC_ENC5 [16] = '{
        5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
    };
    parameter logic [5:0] PLSC_ENC6 [32] = '{
        6'h36, 6'h11, 6'h24, 6'h25, 6'h12, 6'h13, 6'h16, 6'h17,
        6'h22, 6'h31, 6'h37, 6'h27, 6'h32, 6'h33, 6'h34, 6'h35,
        6'h3E, 6'h19, 6'h29, 6'h2D, 6'h1A, 6'h1B, 6'h1E, 6'h1D,
        6'h2A, 6'h2B, 6'h2E, 6'h2F, 6'h3A, 6'h3B, 6'h3C, 6'h3D
    };

    // Six-bit code when six is set, else five-bit code in the low bits
    function automatic logic [5:0] plsc_enc(input logic [4:0] v, input logic six);
        return six ? PLSC_ENC6[v] : {1'h0, PLSC_ENC5[v[3:0]]};
    endfunction

    // Returns {valid, value}
    function automatic logic [5:0] plsc_dec(input logic [5:0] c, input logic six);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if ((six || i < 16) && plsc_enc(5'(i), six) == c) begin
                r = {1'h1, 5'(i)};
            end
        end
        return r;
    endfunction
endpackage

//--- shared/plsc_regs.svh
// Constants of the serial link codec: code symbols, word width, buffer depth.
// Included by bare name; defines only.
`ifndef PLSC_REGS_SVH
`define PLSC_REGS_SVH
`define PLSC_WORD_W 12
`define PLSC_DATA_W 8
`define PLSC_FIFO_DEPTH 16
`define PLSC_SYNC5_HI 5'h18
`define PLSC_SYNC5_LO 5'h11
`define PLSC_SYNC6_HI 6'h30
`define PLSC_SYNC6_LO 6'h23
`define PLSC_CMD5 5'h0D
`define PLSC_CMD6 6'h0D
`define PLSC_LINE_RST 1'h0
`endif

//--- shared/plsc_strm_if.sv
// Valid/ready word stream between the codec and its buffer.
// Assumes both ends on the same clock.
`timescale 1ns/1ps
`include "plsc_regs.svh"
interface plsc_strm_if #(
    parameter int WIDTH = `PLSC_WORD_W
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- sim/plsc_codec_checker.sv
// Pin-level assertions for the serial link codec.
// Assumes one clock, async active-low reset; bound into plsc_codec.
`timescale 1ns/1ps
`include "plsc_regs.svh"
module plsc_codec_checker #(
    parameter int DATA_W = `PLSC_DATA_W
) (
    input wire logic                           clk,
    input wire logic                           rst_n,
    input wire logic                           input_strobe,
    input wire logic                           input_ack_out,
    input wire logic                           capture_next_byte_in,
    input wire logic [DATA_W-1:0]              data_out,
    input wire logic [`PLSC_WORD_W-DATA_W-1:0] command_out,
    input wire logic                           data_strobe_out,
    input wire logic                           command_strobe_out,
    input wire logic                           byte_claimed_out,
    input wire logic                           link_framed_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_dstb_pulse; data_strobe_out |=> !data_strobe_out; endproperty
    property p_data_hold; $changed(data_out) |-> data_strobe_out; endproperty
    property p_cmd_hold; $changed(command_out) |-> command_strobe_out; endproperty
    property p_ack_rise; $rose(input_ack_out) |-> input_strobe && $past(input_strobe, 2); endproperty
    property p_ack_fall; $fell(input_ack_out) |-> !$past(input_strobe, 2); endproperty
    property p_framed_keep; link_framed_out |=> link_framed_out; endproperty
    property p_claim_drop; !capture_next_byte_in [*3] |=> !byte_claimed_out; endproperty
    property p_claim_rise; $rose(byte_claimed_out) |-> $past(capture_next_byte_in, 3); endproperty

    a_dstb_pulse: assert property (p_dstb_pulse) else $error("data strobe wider than one cycle");
    a_data_hold: assert property (p_data_hold) else $error("data output moved without strobe");
    a_cmd_hold: assert property (p_cmd_hold) else $error("command output moved without strobe");
    a_ack_rise: assert property (p_ack_rise) else $error("acknowledge without held strobe");
    a_ack_fall: assert property (p_ack_fall) else $error("acknowledge dropped while strobe high");
    a_framed_keep: assert property (p_framed_keep) else $error("framing lost");
    a_claim_drop: assert property (p_claim_drop) else $error("claim held with capture low");
    a_claim_rise: assert property (p_claim_rise) else $error("claim raised without capture");

    c_data: cover property (data_strobe_out);
    c_cmd: cover property (command_strobe_out);
    c_claim: cover property ($rose(byte_claimed_out));
endmodule // plsc_codec_checker

bind plsc_codec plsc_codec_checker #(.DATA_W(DATA_W)) u_chk (
    .clk                  (clk),
    .rst_n                (rst_n),
    .input_strobe         (input_strobe),
    .input_ack_out        (input_ack_out),
    .capture_next_byte_in (capture_next_byte_in),
    .data_out             (data_out),
    .command_out          (command_out),
    .data_strobe_out      (data_strobe_out),
    .command_strobe_out   (command_strobe_out),
    .byte_claimed_out     (byte_claimed_out),
    .link_framed_out      (link_framed_out)
);

//--- sim/plsc_host_model.sv
// Host partner: offers words on the four-phase strobe/acknowledge handshake.
// Assumes the codec acknowledges within a few tens of clocks.
`timescale 1ns/1ps
`include "plsc_regs.svh"
module plsc_host_model #(
    parameter int DATA_W = `PLSC_DATA_W
) (
    input  wire logic                           clk,
    output logic                                input_strobe,
    output logic [DATA_W-1:0]                   data_in,
    output logic [`PLSC_WORD_W-DATA_W-1:0]      command_in,
    input  wire logic                           input_ack_out,
    output logic                                hs_err
);
    initial begin
        input_strobe = 1'b0;
        data_in = '0;
        command_in = '0;
        hs_err = 1'b0;
    end

    task automatic send(input logic [DATA_W-1:0] d, input logic [`PLSC_WORD_W-DATA_W-1:0] c,
                        input int hold);
        int n;
        n = 0;
        @(posedge clk);
        data_in <= d;
        command_in <= c;
        input_strobe <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (input_ack_out !== 1'b1 && n < 64);
        repeat (hold) @(posedge clk);
        input_strobe <= 1'b0;
        data_in <= ~d;
        command_in <= ~c;
        while (input_ack_out !== 1'b0 && n < 128) begin
            @(posedge clk);
            n++;
        end
        if (n >= 64) hs_err <= 1'b1;
    endtask
endmodule // plsc_host_model

//--- sim/tb_top.sv
// Self-checking bench: host model in front of the codec, line looped back.
// Assumes the default eight-bit width, so code groups are ten bits.
`timescale 1ns/1ps
`include "plsc_regs.svh"
module tb_top;
    localparam int DW = `PLSC_DATA_W;
    localparam int CW = `PLSC_WORD_W - DW;
    logic          clk, rst_n, input_strobe, input_ack_out, serial_line_out, hs_err, prev_line;
    logic          capture_next_byte_in, cascade_en, data_strobe_out, command_strobe_out;
    logic          byte_claimed_out, link_framed_out, ce;
    logic [DW-1:0] data_in, data_out;
    logic [CW-1:0] command_in, command_out;
    logic [9:0]    win;
    logic [12:0]   rx_q[$];
    int            errors, comparisons;
    int            wait_n, max_wait;

    plsc_host_model #(.DATA_W(DW)) u_host (.clk(clk), .input_strobe(input_strobe), .data_in(data_in),
        .command_in(command_in), .input_ack_out(input_ack_out), .hs_err(hs_err));

    plsc_codec #(.DATA_W(DW)) u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .input_strobe(input_strobe),
        .data_in(data_in), .command_in(command_in), .input_ack_out(input_ack_out),
        .serial_line_out(serial_line_out), .serial_line_in(serial_line_out),
        .capture_next_byte_in(capture_next_byte_in), .cascade_en(cascade_en), .data_out(data_out),
        .command_out(command_out), .data_strobe_out(data_strobe_out),
        .command_strobe_out(command_strobe_out), .byte_claimed_out(byte_claimed_out),
        .link_framed_out(link_framed_out));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Line bits recovered from NRZI, received words in order, longest acknowledge wait
    always @(posedge clk) begin
        prev_line <= serial_line_out;
        win <= {win[8:0], serial_line_out ^ prev_line};
        wait_n <= (input_strobe === 1'b1 && input_ack_out === 1'b0) ? wait_n + 1 : 0;
        if (wait_n > max_wait) max_wait <= wait_n;
        if (data_strobe_out === 1'b1) rx_q.push_back({1'b0, {CW{1'b0}}, data_out});
        if (command_strobe_out === 1'b1) rx_q.push_back({1'b1, command_out, {DW{1'b0}}});
    end

    task automatic chk_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_word(input string name, input logic [12:0] exp, input logic [12:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic wait_group(input logic [9:0] g, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < 60 && !hit; i++) begin
            @(posedge clk);
            hit = (win === g);
        end
    endtask

    task automatic pop_rx(output logic [12:0] v);
        for (int i = 0; i < 80 && rx_q.size() == 0; i++) @(posedge clk);
        v = (rx_q.size() != 0) ? rx_q.pop_front() : 'x;
    endtask

    function automatic logic [9:0] dgrp(input logic [7:0] d);
        return {plsc_pkg::PLSC_ENC5[d[7:4]], plsc_pkg::PLSC_ENC5[d[3:0]]};
    endfunction

    task automatic t_idle_sync();
        logic hit;
        wait_group({`PLSC_SYNC5_HI, `PLSC_SYNC5_LO}, hit);
        chk_bit("idle sync group", 1'b1, hit);
        wait_group({`PLSC_SYNC5_HI, `PLSC_SYNC5_LO}, hit);
        chk_bit("repeated sync", 1'b1, hit);
        repeat (10) @(posedge clk);
        chk_bit("framed", 1'b1, link_framed_out);
        chk_word("idle words", 13'h0000, 13'(rx_q.size()));
    endtask

    task automatic t_freeze();
        logic line;
        logic hit;
        @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        line = serial_line_out;
        repeat (8) begin
            @(posedge clk);
            chk_bit("line frozen", line, serial_line_out);
        end
        ce <= 1'b1;
        wait_group({`PLSC_SYNC5_HI, `PLSC_SYNC5_LO}, hit);
        chk_bit("sync after freeze", 1'b1, hit);
        chk_word("words after freeze", 13'h0000, 13'(rx_q.size()));
    endtask

    task automatic t_data();
        logic [7:0]  tbl[5] = '{8'h00, 8'h5A, 8'hA5, 8'hFF, 8'h3C};
        logic        hit;
        logic [12:0] v;
        foreach (tbl[i]) begin
            u_host.send(tbl[i], '0, 0);
            wait_group(dgrp(tbl[i]), hit);
            chk_bit("data group", 1'b1, hit);
            pop_rx(v);
            chk_word("data word", {1'b0, 4'h0, tbl[i]}, v);
        end
    endtask

    task automatic t_burst();
        logic [12:0] v;
        for (int i = 0; i < 4; i++) u_host.send(8'(8'h11 * (i + 1)), '0, i);
        for (int i = 0; i < 4; i++) begin
            pop_rx(v);
            chk_word("burst word", {1'b0, 4'h0, 8'(8'h11 * (i + 1))}, v);
        end
        repeat (40) @(posedge clk);
        chk_word("words after idle", 13'h0000, 13'(rx_q.size()));
        chk_word("data across sync", {5'h00, 8'h44}, {5'h00, data_out});
    endtask

    task automatic t_cmd();
        logic        hit;
        logic [12:0] v;
        for (int c = 1; c < 16; c++) begin
            u_host.send(8'h5A, 4'(c), 2);
            wait_group({`PLSC_CMD5, plsc_pkg::PLSC_ENC5[c]}, hit);
            chk_bit("command group", 1'b1, hit);
            pop_rx(v);
            chk_word("command word", {1'b1, 4'(c), 8'h00}, v);
            chk_word("data under command", {5'h00, 8'h44}, {5'h00, data_out});
        end
    endtask

    task automatic t_busy();
        logic [12:0] v;
        // Host outpaces the drain until the buffer fills and strobes wait for a window
        for (int i = 0; i < 250; i++) u_host.send(8'(i), '0, 0);
        for (int i = 0; i < 250; i++) begin
            pop_rx(v);
            chk_word("busy word", {5'h00, 8'(i)}, v);
        end
        chk_bit("ack deferred", 1'b1, max_wait > 3);
    endtask

    task automatic t_cascade();
        logic [12:0] v;
        @(posedge clk);
        cascade_en <= 1'b1;
        u_host.send(8'h42, '0, 0);
        repeat (40) @(posedge clk);
        chk_word("unclaimed words", 13'h0000, 13'(rx_q.size()));
        capture_next_byte_in <= 1'b1;
        u_host.send(8'h24, '0, 0);
        pop_rx(v);
        chk_word("claimed word", {5'h00, 8'h24}, v);
        chk_bit("claim up", 1'b1, byte_claimed_out);
        repeat (20) @(posedge clk);
        chk_bit("claim after sync", 1'b0, byte_claimed_out);
        capture_next_byte_in <= 1'b0;
        cascade_en <= 1'b0;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (9000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        cascade_en = 1'b0;
        capture_next_byte_in = 1'b0;
        ce = 1'b1;
        wait_n = 0;
        max_wait = 0;
        prev_line = 1'b0;
        win = '0;
        errors = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_idle_sync();
        t_freeze();
        t_data();
        t_burst();
        t_cmd();
        t_busy();
        t_cascade();
        chk_bit("handshake", 1'b0, hs_err);
        complete_run();
    end
endmodule // tb_top
